// ==== logic/pcr_pkg.sv ====
// Package for the express capability and serial ROM word registers.
// Assumes a single core clock domain; offsets are configuration byte offsets.
package pcr_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] PCR_OFF_ROM = 8'hdc;
  localparam logic [7:0] PCR_OFF_CAP = 8'he0;
  localparam logic [7:0] PCR_OFF_DEVCAP = 8'he4;
  localparam logic [7:0] PCR_OFF_IRQ_STAT = 8'hf0;
  localparam logic [7:0] PCR_OFF_IRQ_CLR = 8'hf4;
  localparam logic [7:0] PCR_OFF_IRQ_EN = 8'hf8;
  localparam logic [7:0] PCR_OFF_SPL = 8'hfc;
  // ----------------------------------------
  // Field positions and fixed values
  // ----------------------------------------
  localparam int PCR_BIT_START = 0;
  localparam int PCR_BIT_DIR = 1;
  localparam int PCR_BIT_ERR = 2;
  localparam int PCR_ADDR_LO = 9;
  localparam int PCR_ADDR_HI = 15;
  localparam int PCR_DATA_LO = 16;
  localparam int PCR_DATA_HI = 31;
  localparam logic [7:0] PCR_CAP_ID = 8'h10;
  localparam logic [7:0] PCR_NEXT_PTR = 8'h00;
  localparam logic [3:0] PCR_CAP_VER = 4'h1;
  localparam logic [3:0] PCR_TYPE_UP = 4'h5;
  localparam logic [3:0] PCR_TYPE_DN = 4'h6;
  localparam logic [4:0] PCR_MSG_NUM = 5'h00;
  localparam logic [2:0] PCR_MPS_RST = 3'h1;
  localparam logic [1:0] PCR_PHANTOM = 2'h0;
  localparam logic [2:0] PCR_LAT = 3'h0;
  localparam logic PCR_RBER_RST = 1'b1;
  localparam logic [7:0] PCR_SPL_VAL_RST = 8'h00;
  localparam logic [1:0] PCR_SPL_SCL_RST = 2'h0;
  // Interrupt status bits
  localparam int PCR_EV_DONE = 0;
  localparam int PCR_EV_NACK = 1;
  localparam int PCR_EV_SPL = 2;
  localparam int PCR_EV_W = 3;
  // ----------------------------------------
  // Serial ROM access sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    PCR_IDLE = 2'b00,
    PCR_BUSY = 2'b01,
    PCR_DONE = 2'b10
  } pcr_state_e;
endpackage

// ==== logic/pcr_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clock_i.
`timescale 1ns/1ns
module pcr_sync
  import pcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1;
  logic s2;
  logic s3;
  // ----------------------------------------
  // Sampling chain
  // ----------------------------------------
  // Only s2 reads s1; the filter looks at s2 and s3
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule

// ==== logic/pcr_regs.sv ====
// Express capability and serial ROM word registers of an upstream or downstream bridge port.
// Assumes a simple register port master and an external ROM sequencer handshake.
//
// How it works
// - ROM word address bits 15:9, read-write, reset zero.
// - ROM data bits 31:16, read-write, reset zero, word to write.
// - Finished ROM read without a missing acknowledge loads returned word into the data field.
// - Capability identifier bits 7:0 read constant 10h.
// - Next pointer bits 15:8 read 00h, list ends here.
// - Capability version bits 19:16 read 0001b.
// - Port type reads 0101b upstream, 0110b downstream.
// - Slot bit 24 valid downstream; default from strap or autoload.
// - Interrupt message number bits 29:25 read zero.
// - Max payload supported bits 2:0 reset 001b, overridable by load.
// - Phantom function support bits 4:3 read 00b.
// - Extended tag support bit 5 reads zero.
// - L0s and L1 latency fields read 000b.
// - Role-based error reporting bit 15 resets one, overridable.
// - Upstream captures slot power value and scale from message.
// - Software sets start bit 0, direction bit 1 picks read/write.
// - Missing ROM acknowledge sets error bit 2.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
module pcr_regs
  import pcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic downstream_i,
  input wire logic slot_strap_i,
  input wire logic cfg_load_i,
  input wire logic cfg_slot_i,
  input wire logic [2:0] cfg_mps_i,
  input wire logic cfg_rber_i,
  input wire logic spl_msg_i,
  input wire logic [7:0] spl_value_i,
  input wire logic [1:0] spl_scale_i,
  output logic rom_req_o,
  output logic rom_write_o,
  output logic [6:0] rom_addr_o,
  output logic [15:0] rom_wdata_o,
  input wire logic rom_done_i,
  input wire logic rom_nack_i,
  input wire logic [15:0] rom_rdata_i,
  output logic irq_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  pcr_state_e state;
  pcr_state_e next_state;
  logic start;
  logic dir;
  logic err;
  logic [6:0] waddr;
  logic [15:0] wdata;
  logic slot;
  logic slot_seen;
  logic [2:0] mps;
  logic rber;
  logic [7:0] spl_val;
  logic [1:0] spl_scl;
  logic [PCR_EV_W-1:0] irq_stat;
  logic [PCR_EV_W-1:0] irq_en;
  logic strap_lvl;

  pcr_sync u_strap_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .async_i(slot_strap_i),
    .level_o(strap_lvl)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire sel_rom = addr_i == PCR_OFF_ROM;
  wire sel_cap = addr_i == PCR_OFF_CAP;
  wire sel_dcap = addr_i == PCR_OFF_DEVCAP;
  wire sel_stat = addr_i == PCR_OFF_IRQ_STAT;
  wire sel_clr = addr_i == PCR_OFF_IRQ_CLR;
  wire sel_en = addr_i == PCR_OFF_IRQ_EN;
  wire sel_spl = addr_i == PCR_OFF_SPL;
  wire wr_rom = wr_i && sel_rom;
  // A new access is only taken while idle, so a busy cycle is never disturbed
  wire kick = wr_rom && wdata_i[PCR_BIT_START] && (state == PCR_IDLE);
  wire finish = (state == PCR_BUSY) && rom_done_i;
  wire rd_done = finish && !dir && !rom_nack_i;
  wire up_spl = spl_msg_i && !downstream_i;
  wire [PCR_EV_W-1:0] events = {up_spl, finish && rom_nack_i, finish};
  wire [31:0] rom_word = {wdata, waddr, 6'h00, err, dir, start};
  wire [3:0] port_type = downstream_i ? PCR_TYPE_DN : PCR_TYPE_UP;
  wire slot_rd = downstream_i & slot;
  wire [31:0] cap_word = {2'h0, PCR_MSG_NUM, slot_rd, port_type, PCR_CAP_VER,
                          PCR_NEXT_PTR, PCR_CAP_ID};
  wire [31:0] dcap_word = {4'h0, spl_scl, spl_val, 2'h0, rber, 3'h0, PCR_LAT,
                           PCR_LAT, 1'b0, PCR_PHANTOM, mps};
  wire [31:0] rd_mux = sel_rom ? rom_word :
                       sel_cap ? cap_word :
                       sel_dcap ? dcap_word :
                       sel_stat ? {29'h0, irq_stat} :
                       sel_en ? {29'h0, irq_en} :
                       sel_spl ? {30'h0, downstream_i, strap_lvl} : 32'h0;

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      PCR_IDLE: begin
        if (kick) begin
          next_state = PCR_BUSY;
        end
      end
      PCR_BUSY: begin
        if (rom_done_i) begin
          next_state = PCR_DONE;
        end
      end
      PCR_DONE: begin
        next_state = PCR_IDLE;
      end
      default: begin
        next_state = PCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= PCR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Serial ROM control word
  // ----------------------------------------
  // Address and data are frozen while busy so the sequencer sees stable values
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start <= 1'b0;
      dir <= 1'b0;
      err <= 1'b0;
      waddr <= 7'h00;
      wdata <= 16'h0000;
    end else begin
      if (finish) begin
        start <= 1'b0;
        err <= rom_nack_i;
      end else if (kick) begin
        start <= 1'b1;
        err <= 1'b0;
      end
      if (wr_rom && state == PCR_IDLE) begin
        dir <= wdata_i[PCR_BIT_DIR];
        waddr <= wdata_i[PCR_ADDR_HI:PCR_ADDR_LO];
        wdata <= wdata_i[PCR_DATA_HI:PCR_DATA_LO];
      end
      if (rd_done) begin
        wdata <= rom_rdata_i;
      end
    end
  end

  // ----------------------------------------
  // Loadable capability defaults
  // ----------------------------------------
  // Synchronised strap drives the slot bit every cycle after reset until a load overrides it
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot <= 1'b0;
      slot_seen <= 1'b0;
      mps <= PCR_MPS_RST;
      rber <= PCR_RBER_RST;
    end else begin
      if (cfg_load_i) begin
        slot <= cfg_slot_i;
        mps <= cfg_mps_i;
        rber <= cfg_rber_i;
        slot_seen <= 1'b1;
      end else if (!slot_seen) begin
        slot <= strap_lvl;
      end
    end
  end

  // ----------------------------------------
  // Slot power capture
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spl_val <= PCR_SPL_VAL_RST;
      spl_scl <= PCR_SPL_SCL_RST;
    end else if (up_spl) begin
      spl_val <= spl_value_i;
      spl_scl <= spl_scale_i;
    end
  end

  // ----------------------------------------
  // Interrupt status, enable and read port
  // ----------------------------------------
  // Set wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat <= '0;
      irq_en <= '0;
      irq_o <= 1'b0;
      rdata_o <= 32'h0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_i && sel_clr) ? wdata_i[PCR_EV_W-1:0] : '0)) | events;
      if (wr_i && sel_en) begin
        irq_en <= wdata_i[PCR_EV_W-1:0];
      end
      irq_o <= |(irq_stat & irq_en);
      rdata_o <= rd_i ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // Sequencer outputs
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rom_req_o <= 1'b0;
      rom_write_o <= 1'b0;
      rom_addr_o <= 7'h00;
      rom_wdata_o <= 16'h0000;
    end else begin
      rom_req_o <= kick;
      if (kick) begin
        rom_write_o <= wdata_i[PCR_BIT_DIR];
        rom_addr_o <= wdata_i[PCR_ADDR_HI:PCR_ADDR_LO];
        rom_wdata_o <= wdata_i[PCR_DATA_HI:PCR_DATA_LO];
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_cap_id_const: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_i && sel_cap |=> rdata_o[15:0] == 16'h0010) else $error("cap id wrong");
  a_cap_ver_type: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_i && sel_cap && !downstream_i |=> rdata_o[23:16] == 8'h51)
    else $error("version or type wrong");
  a_msg_num_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_i && sel_cap |=> rdata_o[29:25] == 5'h00) else $error("msg num nonzero");
  a_dcap_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_i && sel_dcap |=> rdata_o[11:3] == 9'h000) else $error("dcap zero fields");
  a_read_loads: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_done |=> wdata == $past(rom_rdata_i)) else $error("read data not loaded");
  a_start_clears: assert property (@(posedge clock_i) disable iff (!nrst_i)
    finish |=> !start && state == PCR_DONE) else $error("start not cleared");
  a_nack_error: assert property (@(posedge clock_i) disable iff (!nrst_i)
    finish && rom_nack_i |=> err && irq_stat[PCR_EV_NACK]) else $error("nack lost");
  a_spl_capture: assert property (@(posedge clock_i) disable iff (!nrst_i)
    up_spl |=> spl_val == $past(spl_value_i) && spl_scl == $past(spl_scale_i))
    else $error("slot power not captured");
  a_kick_busy: assert property (@(posedge clock_i) disable iff (!nrst_i)
    kick |=> start && rom_req_o && state == PCR_BUSY) else $error("start not taken");
endmodule

// ==== verif/pcr_rom_model.sv ====
// Behavioural serial ROM sequencer that sits behind the word registers.
// Assumes requests are one-cycle pulses and address and data stand meanwhile.
`timescale 1ns/1ns
module pcr_rom_model (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [6:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] lat_i,
  input wire logic nack_i,
  output logic done_o,
  output logic nack_o,
  output logic [15:0] rdata_o
);
  // --------------------------------
  // Storage and access timing
  // --------------------------------
  logic [15:0] mem [0:127];
  logic [15:0] word;
  logic [3:0] cnt;
  logic busy;
  logic nack_r;
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 16'h0000;
    end
  end
  // Latency is set per test so slow accesses can overlap register traffic
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy <= 1'b0;
      done_o <= 1'b0;
      cnt <= 4'h0;
      nack_r <= 1'b0;
      word <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      if (req_i) begin
        busy <= 1'b1;
        cnt <= lat_i;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        nack_r <= nack_i;
        if (write_i && !nack_i) begin
          mem[addr_i] <= wdata_i;
        end
        word <= mem[addr_i];
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  // Data lines show no stale word outside the done cycle
  assign rdata_o = done_o ? word : ~word;
  assign nack_o = done_o & nack_r;
endmodule

// ==== verif/pcr_regs_tb.sv ====
// Self-checking bench for the capability and serial ROM word registers.
// Assumes the ROM model file is compiled first.
`timescale 1ns/1ns
module pcr_regs_tb;
  import pcr_pkg::*;
  // Unmapped offset: a write here must leave every register untouched
  localparam logic [7:0] PCR_OFF_E0_DUMMY_GUARD = 8'h40;
  logic clock_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, downstream_i = 1'b0;
  logic slot_strap_i = 1'b1, cfg_load_i = 1'b0, cfg_slot_i = 1'b0, cfg_rber_i = 1'b0;
  logic spl_msg_i = 1'b0, rom_req_o, rom_write_o, rom_done_i, rom_nack_i, irq_o, nack = 1'b0;
  logic [7:0] addr_i = 8'h00, spl_value_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, v;
  logic [2:0] cfg_mps_i = 3'h0;
  logic [1:0] spl_scale_i = 2'h0;
  logic [6:0] rom_addr_o;
  logic [15:0] rom_wdata_o, rom_rdata_i;
  logic [3:0] lat = 4'h2;
  int err_total = 0, num_checks = 0, cycles = 0;
  logic [7:0] row_addr [0:4] = '{8'hdc, 8'he0, 8'he4, 8'hf0, 8'h40};
  logic [31:0] row_exp [0:4] = '{32'h0, 32'h00510010, 32'h00008001, 32'h0, 32'h0};
  pcr_regs dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .downstream_i(downstream_i),
    .slot_strap_i(slot_strap_i), .cfg_load_i(cfg_load_i), .cfg_slot_i(cfg_slot_i),
    .cfg_mps_i(cfg_mps_i), .cfg_rber_i(cfg_rber_i), .spl_msg_i(spl_msg_i),
    .spl_value_i(spl_value_i), .spl_scale_i(spl_scale_i), .rom_req_o(rom_req_o),
    .rom_write_o(rom_write_o), .rom_addr_o(rom_addr_o), .rom_wdata_o(rom_wdata_o),
    .rom_done_i(rom_done_i), .rom_nack_i(rom_nack_i), .rom_rdata_i(rom_rdata_i),
    .irq_o(irq_o));
  pcr_rom_model rom (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(rom_req_o),
    .write_i(rom_write_o), .addr_i(rom_addr_o), .wdata_i(rom_wdata_o), .lat_i(lat),
    .nack_i(nack), .done_o(rom_done_i), .nack_o(rom_nack_i), .rdata_o(rom_rdata_i));
  // --------------------------------
  // Clock, timeout and helpers
  // --------------------------------
  initial begin
    forever #4 clock_i = ~clock_i;
  end
  // Whole run needs well under two thousand cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Polls the start bit with a bounded count
  task automatic wait_rom();
    for (int i = 0; i < 40; i++) begin
      rd(PCR_OFF_ROM, v);
      if (v[0] === 1'b0) begin
        break;
      end
    end
  endtask
  task automatic do_reset();
    nrst_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    do_reset();
    for (int r = 0; r < 5; r++) begin
      rd(row_addr[r], v);
      chk(v, row_exp[r]);
    end
    wr(PCR_OFF_E0_DUMMY_GUARD, 32'h0);
    wr(PCR_OFF_IRQ_EN, 32'h7);
    wr(PCR_OFF_ROM, 32'hbeef5403);
    // The request pulse is launched at this very edge, so look once it has settled
    #1;
    chk({31'h0, rom_req_o}, 32'h1);
    chk({rom_write_o, rom_addr_o, rom_wdata_o}, {1'b1, 7'h2a, 16'hbeef});
    wait_rom();
    chk(v, 32'hbeef5402);
    lat <= 4'ha;
    wr(PCR_OFF_ROM, 32'h12345401);
    wr(PCR_OFF_ROM, 32'h77770001);
    wait_rom();
    chk(v, 32'hbeef5400);
    rd(PCR_OFF_IRQ_STAT, v);
    chk(v, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    nack <= 1'b1;
    wr(PCR_OFF_IRQ_CLR, 32'h7);
    wr(PCR_OFF_ROM, 32'h00005401);
    wait_rom();
    chk({31'h0, v[2]}, 32'h1);
    rd(PCR_OFF_IRQ_STAT, v);
    chk(v, 32'h3);
    wr(PCR_OFF_IRQ_CLR, 32'h7);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(PCR_OFF_CAP, 32'hffffffff);
    wr(PCR_OFF_DEVCAP, 32'hffffffff);
    rd(PCR_OFF_CAP, v);
    chk(v, 32'h00510010);
    @(posedge clock_i);
    cfg_mps_i <= 3'h2;
    cfg_slot_i <= 1'b1;
    cfg_load_i <= 1'b1;
    spl_value_i <= 8'ha5;
    spl_scale_i <= 2'h3;
    spl_msg_i <= 1'b1;
    @(posedge clock_i);
    cfg_load_i <= 1'b0;
    spl_msg_i <= 1'b0;
    rd(PCR_OFF_DEVCAP, v);
    chk(v, {4'h0, 2'h3, 8'ha5, 18'h00002});
    downstream_i <= 1'b1;
    do_reset();
    repeat (8) @(posedge clock_i);
    rd(PCR_OFF_CAP, v);
    chk(v, 32'h01610010);
    @(posedge clock_i);
    spl_msg_i <= 1'b1;
    @(posedge clock_i);
    spl_msg_i <= 1'b0;
    rd(PCR_OFF_DEVCAP, v);
    chk(v, 32'h00008001);
    close_out();
  end
endmodule
